// ==== bcc_pkg.sv ====
package bcc_pkg;

   // =====================================================
   // Timing
   localparam int CLK_MHZ       = 200;
   localparam int SCAN_CYCLE_US = 1600;
   localparam int NDIG          = 4;
   localparam int DIGIT_US      = SCAN_CYCLE_US / NDIG;
   localparam int DIGIT_CYC     = DIGIT_US * CLK_MHZ;
   localparam int LOAD_MAX_US   = 5000;
   localparam int LOAD_MAX_CYC  = LOAD_MAX_US * CLK_MHZ;

   // =====================================================
   // Register offsets
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_IRQ_STAT = 8'h04;
   localparam logic [7:0] A_IRQ_CLR  = 8'h08;
   localparam logic [7:0] A_IRQ_EN   = 8'h0C;
   localparam logic [7:0] A_COUNT    = 8'h10;
   localparam logic [7:0] A_CMP      = 8'h14;
   localparam logic [7:0] A_LATCH    = 8'h18;
   localparam logic [7:0] A_STATE    = 8'h1C;

   // =====================================================
   // Fields and reset values
   localparam int CTRL_EN  = 0;
   localparam logic CTRL_RST = 1'b1;
   localparam int NEV      = 4;
   localparam int EV_EQ    = 0;
   localparam int EV_ZERO  = 1;
   localparam int EV_LDONE = 2;
   localparam int EV_WRAP  = 3;
   localparam int ST_EQ    = 0;
   localparam int ST_ZERO  = 1;
   localparam int ST_VALID = 2;
   localparam int ST_BUSY  = 3;
   localparam int ST_DC    = 4;
   localparam int ST_LC    = 6;
   localparam int ST_LR    = 8;
   localparam logic [13:0] SYNC_RST = 14'h000C;

   // =====================================================
   // Types
   typedef enum logic [0:0] {
      BCC_LD_IDLE = 1'b0,
      BCC_LD_BUSY = 1'b1
   } bcc_ld_state_t;

   typedef enum logic [1:0] {
      BCC_TL_LOW  = 2'b00,
      BCC_TL_HIGH = 2'b01,
      BCC_TL_OPEN = 2'b10
   } bcc_tl_t;

   function automatic bcc_tl_t bcc_tl_decode(input logic drv,
                                             input logic lvl);
      return drv ? (lvl ? BCC_TL_HIGH : BCC_TL_LOW) : BCC_TL_OPEN;
   endfunction

endpackage

// ==== bcc_scan_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface bcc_scan_if;
   logic       run;
   logic       restart;
   logic [1:0] phase;
   logic       digit_end;
   logic       cycle_end;
   modport scanner (input run, input restart, output phase,
                    output digit_end, output cycle_end);
   modport ctl (output run, output restart, input phase,
                input digit_end, input cycle_end);
endinterface
`default_nettype wire

// ==== bcc_scan.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcc_scan #(
   parameter int DIG_CYC = bcc_pkg::DIGIT_CYC
) (
   input wire logic   clk,
   input wire logic   nrst,
   bcc_scan_if.scanner sp
);
   localparam int PW = $clog2(DIG_CYC);
   localparam logic [PW-1:0] PRE_LAST = PW'(DIG_CYC - 1);

   logic [PW-1:0] pre_reg;
   logic [1:0]    ph_reg;

   // =====================================================
   // Digit timebase
   wire last = sp.run & (pre_reg == PRE_LAST);
   assign sp.phase     = ph_reg;
   assign sp.digit_end = last & ~sp.restart;
   assign sp.cycle_end = sp.digit_end & (ph_reg == 2'h3);

   // Restart always lands on the MSD phase
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         pre_reg <= '0;
         ph_reg  <= 2'h0;
      end else if (sp.restart) begin
         pre_reg <= '0;
         ph_reg  <= 2'h0;
      end else if (last) begin
         pre_reg <= '0;
         ph_reg  <= ph_reg + 2'h1;
      end else if (sp.run) begin
         pre_reg <= pre_reg + {{(PW-1){1'b0}}, 1'b1};
      end
   end

   // =====================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   scan_restart_a: assert property (
      sp.restart |=> sp.phase == 2'h0 && pre_reg == '0)
      else $error("scan did not restart at MSD");
   scan_order_a: assert property (
      sp.digit_end |=> sp.phase == $past(sp.phase) + 2'h1)
      else $error("scan phase out of order");
endmodule
`default_nettype wire

// ==== bcc_counter.sv ====
// Function
// - Load completes at the end of the scan cycle in which release falls
// - Flags marked invalid while loading
// - Equality compares counter and register bitwise
// - Simultaneous loads write same value both
// - Counter reload inhibits counting; edges lost
// - Compare register kept; counter clear spares it outside a register load
// - Three-level controls decoded low, high, open
// - Counter control low disables BCD drivers
// - Loading scans on internal timebase, restarted at load start
// - Equality flag when counter equals register
// - Zero flag when counter holds zero
// - Count rising edge steps up or down
// - Clear input zeroes all four decades
// - Whole MSD-first cycles, resampled at end
// - Store low copies counter into latch
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module bcc_counter #(
   parameter int DIG_CYC  = bcc_pkg::DIGIT_CYC,
   parameter int LOAD_MAX = bcc_pkg::LOAD_MAX_CYC
) (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   output logic             irq,
   input  wire logic        count_in,
   input  wire logic        up_down,
   input  wire logic        ctr_clear_n,
   input  wire logic        store_n,
   input  wire logic        counter_preset_ctl_drv,
   input  wire logic        counter_preset_ctl_lvl,
   input  wire logic        compare_preset_ctl_drv,
   input  wire logic        compare_preset_ctl_lvl,
   input  wire logic        display_control_in_drv,
   input  wire logic        display_control_in_lvl,
   input  wire logic [3:0]  bcd_in,
   output logic      [3:0]  bcd_out,
   output logic             bcd_oe,
   output logic             msd_digit_strobe,
   output logic             mid_hi_digit_strobe,
   output logic             mid_lo_digit_strobe,
   output logic             lsd_digit_strobe,
   output logic             equal_flag,
   output logic             zero_flag,
   output logic             flags_valid
);
   localparam int NS = 14;
   localparam int NE = bcc_pkg::NEV;

   // =====================================================
   // Pin synchronisers
   logic [NS-1:0] meta_reg;
   logic [NS-1:0] sync_reg;
   wire  [NS-1:0] pins_raw = {bcd_in,
                              display_control_in_lvl,
                              display_control_in_drv,
                              compare_preset_ctl_lvl,
                              compare_preset_ctl_drv,
                              counter_preset_ctl_lvl,
                              counter_preset_ctl_drv,
                              store_n, ctr_clear_n,
                              up_down, count_in};

   // Clear and store idle high so reset looks quiet
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_reg <= bcc_pkg::SYNC_RST;
         sync_reg <= bcc_pkg::SYNC_RST;
      end else begin
         meta_reg <= pins_raw;
         sync_reg <= meta_reg;
      end
   end

   wire       s_count   = sync_reg[0];
   wire       s_up      = sync_reg[1];
   wire       s_clr_n   = sync_reg[2];
   wire       s_store_n = sync_reg[3];
   wire [3:0] s_bcd     = sync_reg[13:10];

   // =====================================================
   // Three-level controls
   bcc_pkg::bcc_tl_t lc_mode;
   bcc_pkg::bcc_tl_t lr_mode;
   bcc_pkg::bcc_tl_t dc_mode;
   assign lc_mode = bcc_pkg::bcc_tl_decode(sync_reg[4], sync_reg[5]);
   assign lr_mode = bcc_pkg::bcc_tl_decode(sync_reg[6], sync_reg[7]);
   assign dc_mode = bcc_pkg::bcc_tl_decode(sync_reg[8], sync_reg[9]);
   wire lc_hi   = (lc_mode == bcc_pkg::BCC_TL_HIGH);
   wire lr_hi   = (lr_mode == bcc_pkg::BCC_TL_HIGH);
   wire lc_lo   = (lc_mode == bcc_pkg::BCC_TL_LOW);
   wire lr_lo   = (lr_mode == bcc_pkg::BCC_TL_LOW);
   wire both_op = (lc_mode == bcc_pkg::BCC_TL_OPEN) &
                  (lr_mode == bcc_pkg::BCC_TL_OPEN);

   // =====================================================
   // Edge detectors
   logic cnt_prev_reg;
   logic lc_prev_reg;
   logic lr_prev_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_prev_reg <= 1'b0;
         lc_prev_reg  <= 1'b0;
         lr_prev_reg  <= 1'b0;
      end else begin
         cnt_prev_reg <= s_count;
         lc_prev_reg  <= lc_hi;
         lr_prev_reg  <= lr_hi;
      end
   end
   wire tick    = s_count & ~cnt_prev_reg;
   wire ld_rise = (lc_hi & ~lc_prev_reg) | (lr_hi & ~lr_prev_reg);

   // =====================================================
   // Scan sequencer
   bcc_scan_if sp ();
   bcc_scan #(
      .DIG_CYC (DIG_CYC)
   ) u_scan (
      .clk  (clk),
      .nrst (nrst),
      .sp   (sp)
   );

   // =====================================================
   // Load state machine
   bcc_pkg::bcc_ld_state_t st_reg;
   bcc_pkg::bcc_ld_state_t st_next;
   logic tgt_c_reg;
   logic tgt_c_next;
   logic tgt_r_reg;
   logic tgt_r_next;
   logic ldone;
   wire  busy  = (st_reg == bcc_pkg::BCC_LD_BUSY);
   wire  start = ~busy & ld_rise;

   // Controls are resampled only at the end of a whole cycle
   always_comb begin
      st_next    = st_reg;
      tgt_c_next = tgt_c_reg;
      tgt_r_next = tgt_r_reg;
      ldone      = 1'b0;
      unique case (st_reg)
         bcc_pkg::BCC_LD_IDLE: begin
            if (start) begin
               st_next    = bcc_pkg::BCC_LD_BUSY;
               tgt_c_next = lc_hi;
               tgt_r_next = lr_hi;
            end
         end
         bcc_pkg::BCC_LD_BUSY: begin
            if (sp.cycle_end) begin
               if (lc_hi | lr_hi) begin
                  tgt_c_next = lc_hi;
                  tgt_r_next = lr_hi;
               end else begin
                  st_next = bcc_pkg::BCC_LD_IDLE;
                  ldone   = 1'b1;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         st_reg    <= bcc_pkg::BCC_LD_IDLE;
         tgt_c_reg <= 1'b0;
         tgt_r_reg <= 1'b0;
      end else begin
         st_reg    <= st_next;
         tgt_c_reg <= tgt_c_next;
         tgt_r_reg <= tgt_r_next;
      end
   end

   // No external scan clock exists; loads run on the internal one
   assign sp.restart = start;
   assign sp.run     = busy | start | ~lr_lo;

   // =====================================================
   // Decades and load path
   logic [15:0] cnt_reg;
   logic [15:0] cmp_reg;
   logic [15:0] latch_reg;
   logic [15:0] inc_val;
   logic [15:0] dec_val;
   logic [15:0] ld_mask;
   logic [4:0]  cu;
   logic [4:0]  cd;
   wire  [1:0]  ld_dig = ~sp.phase; // MSD is phase 0
   assign cu[0] = 1'b1;
   assign cd[0] = 1'b1;

   // Ripple carry and borrow across the four decades
   for (genvar i = 0; i < bcc_pkg::NDIG; i++) begin : g_dec
      wire [3:0] d = cnt_reg[4*i +: 4];
      assign cu[i+1] = cu[i] & (d == 4'h9);
      assign cd[i+1] = cd[i] & (d == 4'h0);
      assign inc_val[4*i +: 4] = ~cu[i] ? d :
                                 (d == 4'h9) ? 4'h0 : d + 4'h1;
      assign dec_val[4*i +: 4] = ~cd[i] ? d :
                                 (d == 4'h0) ? 4'h9 : d - 4'h1;
      assign ld_mask[4*i +: 4] = {4{ld_dig == 2'(i)}};
   end

   logic ctrl_en_reg;
   wire  clr_act = ~s_clr_n;
   wire  ld_wr   = busy & sp.digit_end;
   // Clear forces the entry data to zero, as on the pins
   wire  [3:0]  ld_data = clr_act ? 4'h0 : s_bcd;
   wire  [15:0] ld_word = {4{ld_data}} & ld_mask;
   // A reload window swallows count edges that land in it
   wire  cnt_inh = clr_act | lc_hi | (busy & tgt_c_reg) |
                   ~ctrl_en_reg;
   wire  cnt_go  = tick & ~cnt_inh;
   wire  wrap    = cnt_go & (s_up ? cu[4] : cd[4]);
   wire  [15:0] cnt_next =
      clr_act              ? 16'h0000 :
      (ld_wr & tgt_c_reg)  ? (cnt_reg & ~ld_mask) | ld_word :
      cnt_go               ? (s_up ? inc_val : dec_val) :
                             cnt_reg;
   // Only a register load touches the compare value
   wire  [15:0] cmp_next = (ld_wr & tgt_r_reg) ?
                           (cmp_reg & ~ld_mask) | ld_word : cmp_reg;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_reg   <= 16'h0000;
         cmp_reg   <= 16'h0000;
         latch_reg <= 16'h0000;
      end else begin
         cnt_reg   <= cnt_next;
         cmp_reg   <= cmp_next;
         latch_reg <= s_store_n ? latch_reg : cnt_reg;
      end
   end

   // =====================================================
   // Flags and display outputs
   wire eq_w   = (cnt_reg == cmp_reg);
   wire zero_w = (cnt_reg == 16'h0000);
   logic [3:0] strobe_reg;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         equal_flag  <= 1'b0;
         zero_flag   <= 1'b0;
         flags_valid <= 1'b0;
         strobe_reg  <= 4'h0;
         bcd_out     <= 4'h0;
         bcd_oe      <= 1'b0;
      end else begin
         equal_flag  <= eq_w;
         zero_flag   <= zero_w;
         flags_valid <= ~busy & ~start;
         strobe_reg  <= sp.run ? (4'h8 >> sp.phase) : 4'h0;
         bcd_out     <= latch_reg[{ld_dig, 2'b00} +: 4];
         bcd_oe      <= ~busy & ~start & both_op;
      end
   end
   assign msd_digit_strobe    = strobe_reg[3];
   assign mid_hi_digit_strobe = strobe_reg[2];
   assign mid_lo_digit_strobe = strobe_reg[1];
   assign lsd_digit_strobe    = strobe_reg[0];

   // =====================================================
   // AHB-Lite slave, zero wait states
   logic       dp_wr_reg;
   logic [7:0] dp_addr_reg;
   logic [NE-1:0] stat_reg;
   logic [NE-1:0] en_reg;
   logic [NE-1:0] ev;
   logic [31:0]   rd_next;
   logic [31:0]   state_w;
   wire ap_ok = hsel & htrans[1] & hready;
   wire ap_in = (haddr[31:8] == 24'h000000);
   wire wr_ctrl = dp_wr_reg & (dp_addr_reg == bcc_pkg::A_CTRL);
   wire wr_en   = dp_wr_reg & (dp_addr_reg == bcc_pkg::A_IRQ_EN);
   wire wr_clr  = dp_wr_reg & (dp_addr_reg == bcc_pkg::A_IRQ_CLR);
   wire [NE-1:0] clr_w = wr_clr ? hwdata[NE-1:0] : {NE{1'b0}};

   // Events are edges, so a held flag does not re-raise
   always_comb begin
      ev = {NE{1'b0}};
      ev[bcc_pkg::EV_EQ]    = eq_w & ~equal_flag;
      ev[bcc_pkg::EV_ZERO]  = zero_w & ~zero_flag;
      ev[bcc_pkg::EV_LDONE] = ldone;
      ev[bcc_pkg::EV_WRAP]  = wrap;
   end

   always_comb begin
      state_w = 32'h00000000;
      state_w[bcc_pkg::ST_EQ]     = equal_flag;
      state_w[bcc_pkg::ST_ZERO]   = zero_flag;
      state_w[bcc_pkg::ST_VALID]  = flags_valid;
      state_w[bcc_pkg::ST_BUSY]   = busy;
      state_w[bcc_pkg::ST_DC +: 2] = dc_mode;
      state_w[bcc_pkg::ST_LC +: 2] = lc_mode;
      state_w[bcc_pkg::ST_LR +: 2] = lr_mode;
   end

   // Unmapped and write-only offsets read as zero
   always_comb begin
      rd_next = 32'h00000000;
      case (haddr[7:0])
         bcc_pkg::A_CTRL:     rd_next[0]      = ctrl_en_reg;
         bcc_pkg::A_IRQ_STAT: rd_next[NE-1:0] = stat_reg;
         bcc_pkg::A_IRQ_EN:   rd_next[NE-1:0] = en_reg;
         bcc_pkg::A_COUNT:    rd_next[15:0]   = cnt_reg;
         bcc_pkg::A_CMP:      rd_next[15:0]   = cmp_reg;
         bcc_pkg::A_LATCH:    rd_next[15:0]   = latch_reg;
         bcc_pkg::A_STATE:    rd_next         = state_w;
         default:             rd_next         = 32'h00000000;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         dp_wr_reg   <= 1'b0;
         dp_addr_reg <= 8'h00;
         hrdata      <= 32'h00000000;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end else begin
         dp_wr_reg   <= ap_ok & hwrite & ap_in;
         dp_addr_reg <= ap_ok ? haddr[7:0] : dp_addr_reg;
         hrdata      <= (ap_ok & ~hwrite & ap_in) ? rd_next : 32'h0;
         hreadyout   <= 1'b1;
         hresp       <= 1'b0;
      end
   end

   // Set beats clear when both land in one cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         ctrl_en_reg <= bcc_pkg::CTRL_RST;
         en_reg      <= {NE{1'b0}};
         stat_reg    <= {NE{1'b0}};
         irq         <= 1'b0;
      end else begin
         ctrl_en_reg <= wr_ctrl ? hwdata[bcc_pkg::CTRL_EN] : ctrl_en_reg;
         en_reg      <= wr_en ? hwdata[NE-1:0] : en_reg;
         stat_reg    <= (stat_reg & ~clr_w) | ev;
         irq         <= |(stat_reg & en_reg);
      end
   end

   // =====================================================
   // Checks
   localparam int RW = $clog2(LOAD_MAX) + 1;
   logic [RW-1:0] rel_cnt;
   // Cycles spent loading after both controls let go
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rel_cnt <= '0;
      end else begin
         rel_cnt <= (busy & ~lc_hi & ~lr_hi) ? rel_cnt + 1'b1 : '0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence ld_go_s;
      start ##1 busy;
   endsequence
   sequence both_wr_s;
      ld_wr && tgt_c_reg && tgt_r_reg;
   endsequence

   load_time_a: assert property (
      rel_cnt <= RW'(LOAD_MAX))
      else $error("load ran past its longest time");
   load_start_a: assert property (
      ld_go_s |-> tgt_c_reg == $past(lc_hi, 1) && sp.phase == 2'h0)
      else $error("load started with wrong targets");
   flag_valid_a: assert property (
      busy |=> !flags_valid)
      else $error("flags shown valid while loading");
   both_same_a: assert property (
      both_wr_s |=> ((cnt_reg ^ cmp_reg) & $past(ld_mask)) == 16'h0)
      else $error("joint load gave different digits");
   reload_inh_a: assert property (
      busy && tgt_c_reg && !ld_wr && s_clr_n |=> $stable(cnt_reg))
      else $error("counter moved during its reload");
   cmp_hold_a: assert property (
      !busy |=> $stable(cmp_reg))
      else $error("compare value changed without load");
   drv_off_a: assert property (
      lc_lo |=> !bcd_oe)
      else $error("BCD drivers on with counter control low");
   equal_flag_a: assert property (
      cnt_reg == cmp_reg |=> equal_flag)
      else $error("equality flag missing");
   zero_flag_a: assert property (
      zero_flag |-> $past(cnt_reg) == 16'h0000)
      else $error("zero flag with nonzero count");
   clear_a: assert property (
      !s_clr_n |=> (cnt_reg == 16'h0000) ##1 zero_flag)
      else $error("clear did not zero the counter");
   wrap_up_a: assert property (
      cnt_go && s_up && cnt_reg == 16'h9999 |=> cnt_reg == 16'h0000)
      else $error("no wrap from 9999 upward");
   step_a: assert property (
      cnt_go && !s_up && cnt_reg == 16'h0010 |=> cnt_reg == 16'h0009)
      else $error("down count borrow wrong");
endmodule
`default_nettype wire

// ==== bcc_dummy_end.sv ====
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// ==== bcc_thumbwheel.sv ====
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Thumbwheel bank on the shared BCD lines, one decade a strobe
module bcc_thumbwheel (
   input  wire logic [15:0] preset,
   input  wire logic        msd_digit_strobe,
   input  wire logic        mid_hi_digit_strobe,
   input  wire logic        mid_lo_digit_strobe,
   input  wire logic        lsd_digit_strobe,
   output logic      [3:0]  bcd_in
);
   // Diodes isolate the decades; with no strobe the pulls read 0000
   assign bcd_in = msd_digit_strobe    ? preset[15:12] :
                   mid_hi_digit_strobe ? preset[11:8]  :
                   mid_lo_digit_strobe ? preset[7:4]   :
                   lsd_digit_strobe    ? preset[3:0]   : 4'h0;
endmodule
`default_nettype wire

// ==== bcd_updown_counter_compare_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module bcd_updown_counter_compare_tb;
   // ==========================================================
   // Signals, short scan phase so a load is 32 cycles
   localparam int DIG  = 8;
   localparam int LMAX = 64;
   logic        clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic        rd_dp = 1'b0, count_in = 1'b0, up_down = 1'b1;
   logic        ctr_clear_n = 1'b1, store_n = 1'b1;
   logic        counter_preset_ctl_drv = 1'b0, counter_preset_ctl_lvl = 1'b1;
   logic        compare_preset_ctl_drv = 1'b0, compare_preset_ctl_lvl = 1'b1;
   logic        display_control_in_drv = 1'b0, display_control_in_lvl = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0]  htrans = 2'b00;
   logic [2:0]  hsize = 3'b010;
   logic [15:0] tw_val = 16'h0;
   logic [3:0]  bcd_in, bcd_out;
   logic        hreadyout, hresp, irq, bcd_oe, equal_flag, zero_flag;
   logic        flags_valid, msd_digit_strobe, mid_hi_digit_strobe;
   logic        mid_lo_digit_strobe, lsd_digit_strobe;
   logic [31:0] exp_q[$], msk_q[$];
   int          bad_count = 0, n_tests = 0, v, w;

   // 200 MHz clock
   always #2.5 clk = ~clk;

   bcc_counter #(.DIG_CYC(DIG), .LOAD_MAX(LMAX)) dut_u (
      .clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize,
      .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .irq,
      .count_in, .up_down, .ctr_clear_n, .store_n,
      .counter_preset_ctl_drv, .counter_preset_ctl_lvl,
      .compare_preset_ctl_drv, .compare_preset_ctl_lvl,
      .display_control_in_drv, .display_control_in_lvl,
      .bcd_in, .bcd_out, .bcd_oe, .msd_digit_strobe, .mid_hi_digit_strobe,
      .mid_lo_digit_strobe, .lsd_digit_strobe, .equal_flag, .zero_flag,
      .flags_valid);

   bcc_thumbwheel tw_u (.preset(tw_val), .msd_digit_strobe,
      .mid_hi_digit_strobe, .mid_lo_digit_strobe, .lsd_digit_strobe,
      .bcd_in);

   // ==========================================================
   // Report and compare helpers
   task automatic results;
      $display("comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
         bad_count++;
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   function automatic logic [15:0] to_bcd(input int x);
      return {4'(x / 1000 % 10), 4'(x / 100 % 10), 4'(x / 10 % 10),
              4'(x % 10)};
   endfunction

   // ==========================================================
   // Bus master: hold each phase until hready is seen at an edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         chk("hready wait", 32'h1, 32'h0);
         results();
      end
   endtask

   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [31:0] m);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= w ? d : 32'h0;
      rd_dp <= ~w;
      if (!w) begin
         exp_q.push_back(d);
         msk_q.push_back(m);
      end
      wait_rdy();
      rd_dp <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hFFFF_FFFF);
      bus(1'b0, {24'h0, a}, e, m);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, {24'h0, a}, d, 32'h0);
   endtask

   // Read data are judged where the data phase completes
   always @(posedge clk) begin : mon
      logic [31:0] e, m;
      if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         m = msk_q.pop_front();
         chk("read data", e & m, hrdata & m);
         chk("hresp", 32'h0, 32'(hresp));
      end
   end

   // Count pulses stay 3 cycles high and low so the sync sees each one
   task automatic pulse(input logic up, input int k);
      up_down <= up;
      cyc(3);
      repeat (k) begin
         count_in <= 1'b1;
         cyc(3);
         count_in <= 1'b0;
         cyc(3);
      end
      cyc(4);
   endtask

   task automatic load(input logic c, input logic r, input int val);
      int n;
      tw_val <= to_bcd(val);
      counter_preset_ctl_lvl <= 1'b1;
      counter_preset_ctl_drv <= c;
      compare_preset_ctl_drv <= r;
      cyc(6);
      counter_preset_ctl_drv <= 1'b0;
      compare_preset_ctl_drv <= 1'b0;
      chk("flags valid", 32'h0, 32'(flags_valid));
      chk("bcd oe", 32'h0, 32'(bcd_oe));
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (flags_valid !== 1'b1 && n < LMAX);
      chk("load time", 32'h1, 32'(flags_valid));
      if (flags_valid !== 1'b1)
         results();
      // Next activation kept a full load time away
      cyc(LMAX);
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      v = $urandom(30582);
      cyc(4);
      nrst <= 1'b1;
      cyc(1);
      rd(bcc_pkg::A_CTRL, 32'h1);
      rd(bcc_pkg::A_IRQ_EN, 32'h0);
      rd(bcc_pkg::A_COUNT, 32'h0);
      rd(bcc_pkg::A_STATE, 32'h2A7, 32'h3FF);
      bus(1'b0, 32'h100, 32'h0, 32'hFFFF_FFFF);
      for (int m = 0; m < 3; m++) begin
         display_control_in_drv <= (m != 2);
         display_control_in_lvl <= (m == 1);
         cyc(4);
         rd(bcc_pkg::A_STATE, 32'(m) << 4, 32'h30);
      end
      wr(bcc_pkg::A_IRQ_CLR, 32'hF);
      rd(bcc_pkg::A_IRQ_STAT, 32'h0);
      v = $urandom_range(12, 3);
      pulse(1'b1, v);
      rd(bcc_pkg::A_COUNT, 32'(to_bcd(v)));
      chk("zero flag", 32'h0, 32'(zero_flag));
      pulse(1'b0, v + 1);
      rd(bcc_pkg::A_COUNT, 32'h9999);
      pulse(1'b1, 1);
      rd(bcc_pkg::A_COUNT, 32'h0);
      rd(bcc_pkg::A_IRQ_STAT, 32'h8, 32'h8);
      chk("irq masked", 32'h0, 32'(irq));
      wr(bcc_pkg::A_IRQ_EN, 32'h8);
      cyc(2);
      chk("irq", 32'h1, 32'(irq));
      wr(bcc_pkg::A_IRQ_CLR, 32'h8);
      cyc(2);
      chk("irq cleared", 32'h0, 32'(irq));
      v = $urandom_range(9990, 0);
      load(1'b1, 1'b1, v);
      rd(bcc_pkg::A_COUNT, 32'(to_bcd(v)));
      rd(bcc_pkg::A_CMP, 32'(to_bcd(v)));
      chk("equal flag", 32'h1, 32'(equal_flag));
      rd(bcc_pkg::A_IRQ_STAT, 32'h4, 32'h4);
      load(1'b0, 1'b1, v + 2);
      rd(bcc_pkg::A_CMP, 32'(to_bcd(v + 2)));
      rd(bcc_pkg::A_COUNT, 32'(to_bcd(v)));
      chk("equal flag", 32'h0, 32'(equal_flag));
      pulse(1'b1, 2);
      chk("equal flag", 32'h1, 32'(equal_flag));
      store_n <= 1'b0;
      cyc(4);
      store_n <= 1'b1;
      pulse(1'b1, 1);
      rd(bcc_pkg::A_LATCH, 32'(to_bcd(v + 2)));
      // Catch the LSD phase so the latched digit can be judged
      w = 0;
      while (lsd_digit_strobe !== 1'b1 && w < 4 * DIG) begin
         cyc(1);
         w++;
      end
      chk("lsd strobe", 32'h1, 32'(lsd_digit_strobe));
      if (lsd_digit_strobe !== 1'b1)
         results();
      chk("bcd out", 32'(to_bcd(v + 2) & 16'h000F), 32'(bcd_out));
      // Divider loop: clear follows equality after a short delay
      pulse(1'b0, 1);
      chk("equal flag", 32'h1, 32'(equal_flag));
      ctr_clear_n <= 1'b0;
      pulse(1'b1, 1);
      ctr_clear_n <= 1'b1;
      cyc(4);
      rd(bcc_pkg::A_COUNT, 32'h0);
      rd(bcc_pkg::A_CMP, 32'(to_bcd(v + 2)));
      counter_preset_ctl_lvl <= 1'b0;
      counter_preset_ctl_drv <= 1'b1;
      cyc(4);
      chk("bcd oe", 32'h0, 32'(bcd_oe));
      counter_preset_ctl_drv <= 1'b0;
      cyc(4);
      chk("bcd oe", 32'h1, 32'(bcd_oe));
      // Compare control low switches the scan off
      compare_preset_ctl_lvl <= 1'b0;
      compare_preset_ctl_drv <= 1'b1;
      cyc(6);
      chk("strobes", 32'h0, 32'(msd_digit_strobe | lsd_digit_strobe));
      compare_preset_ctl_drv <= 1'b0;
      compare_preset_ctl_lvl <= 1'b1;
      cyc(4);
      wr(bcc_pkg::A_CTRL, 32'h0);
      pulse(1'b1, 2);
      rd(bcc_pkg::A_COUNT, 32'h0);
      cyc(4);
      results();
   end
endmodule
`default_nettype wire
